/* File: verilog/flash_ctrl_pkg.sv */
// Shared constants, register map and state encoding of the flash self-program controller.
package flash_ctrl_pkg;
   // Clock and self-timed operation length.
   localparam int unsigned CLK_PERIOD_PS = 8000;
   localparam int unsigned OP_TIME_NS = 2000;
   localparam int unsigned OP_WAIT_CYCLES = (OP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // Memory geometry.
   localparam int unsigned WORD_W = 14;
   localparam int unsigned ADDR_W = 15;
   localparam int unsigned LATCH_COUNT = 32;
   localparam int unsigned LATCH_IDX_W = 5;
   localparam int unsigned ROW_W = ADDR_W - LATCH_IDX_W;
   localparam logic [WORD_W-1:0] BLANK_WORD = 14'h3fff;

   // Register byte offsets on the APB.
   localparam logic [7:0] OFS_DATA_LOW = 8'h00;
   localparam logic [7:0] OFS_DATA_HIGH = 8'h04;
   localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
   localparam logic [7:0] OFS_ADDR_HIGH = 8'h0c;
   localparam logic [7:0] OFS_CONTROL = 8'h10;
   localparam logic [7:0] OFS_UNLOCK = 8'h14;

   // Control register bit positions.
   localparam int unsigned CTRL_READ_BIT = 0;
   localparam int unsigned CTRL_WRITE_BIT = 1;
   localparam int unsigned CTRL_ENABLE_BIT = 2;
   localparam int unsigned CTRL_ERROR_BIT = 3;
   localparam int unsigned CTRL_ERASE_BIT = 4;
   localparam int unsigned CTRL_LATCH_BIT = 5;
   localparam int unsigned CTRL_CFG_BIT = 6;

   // Reset values.
   localparam logic [7:0] ADDR_LOW_RST = 8'h00;
   localparam logic [6:0] ADDR_HIGH_RST = 7'h00;
   localparam logic [WORD_W-1:0] DATA_RST = 14'h0000;
   localparam logic CTRL_BIT_RST = 1'b0;

   // Unlock keys, in the order software must write them.
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;

   // Configuration space locations, with the space bit on top.
   localparam logic [15:0] CFG_USER_FIRST = 16'h8000;
   localparam logic [15:0] CFG_USER_LAST = 16'h8003;
   localparam logic [15:0] CFG_IDENT = 16'h8006;
   localparam logic [15:0] CFG_WORD_ONE = 16'h8007;
   localparam logic [15:0] CFG_WORD_TWO = 16'h8008;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_READ = 6'b000010,
      ST_LOAD = 6'b000100,
      ST_PROG = 6'b001000,
      ST_ERASE = 6'b010000,
      ST_WAIT = 6'b100000
   } op_state_t;
endpackage

/* File: verilog/flash_write_latches.sv */
// Row of write latches that collects words before a row program.
`timescale 1ns/1ps
module flash_write_latches import flash_ctrl_pkg::*; #(
   parameter int unsigned COUNT = LATCH_COUNT,
   parameter int unsigned W = WORD_W
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load_en,
   input wire logic [$clog2(COUNT)-1:0] load_idx,
   input wire logic [W-1:0] load_word,
   input wire logic blank_all,
   input wire logic [$clog2(COUNT)-1:0] rd_idx,
   output logic [W-1:0] rd_word
);
   logic [W-1:0] latch_mem [COUNT];

   // Each latch returns to blank when the timed wait of a program or erase ends.
   for (genvar i = 0; i < COUNT; i++) begin : g_latch
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            latch_mem[i] <= W'(BLANK_WORD);
         end else if (blank_all) begin
            latch_mem[i] <= W'(BLANK_WORD);
         end else if (load_en && load_idx == ($clog2(COUNT))'(i)) begin
            latch_mem[i] <= load_word;
         end
      end
   end

   assign rd_word = latch_mem[rd_idx];
endmodule

/* File: verilog/flash_word_store.sv */
// Program memory array and configuration space words.
`timescale 1ns/1ps
module flash_word_store import flash_ctrl_pkg::*; #(
   parameter int unsigned DEPTH = 2 ** ADDR_W,
   parameter logic [WORD_W-1:0] DEVICE_ID_WORD = 14'h1234,
   parameter logic [WORD_W-1:0] CONFIG_WORD_1 = 14'h3fff,
   parameter logic [WORD_W-1:0] CONFIG_WORD_2 = 14'h3fff
) (
   input wire logic sys_clk,
   input wire logic cfg_sel,
   input wire logic [ADDR_W-1:0] word_addr,
   output logic [WORD_W-1:0] rd_word,
   input wire logic wr_en,
   input wire logic [WORD_W-1:0] wr_word
);
   // Nonvolatile contents: deliberately not touched by reset.
   logic [WORD_W-1:0] pm_mem [DEPTH];
   logic [WORD_W-1:0] user_id_mem [4];
   logic [15:0] cfg_addr;
   logic user_hit;
   logic [WORD_W-1:0] cfg_word;

   // Configuration space decode.
   assign cfg_addr = {1'b1, word_addr};
   assign user_hit = cfg_addr >= CFG_USER_FIRST && cfg_addr <= CFG_USER_LAST;
   assign cfg_word = user_hit ? user_id_mem[cfg_addr[1:0]] :
                     cfg_addr == CFG_IDENT ? DEVICE_ID_WORD :
                     cfg_addr == CFG_WORD_ONE ? CONFIG_WORD_1 :
                     cfg_addr == CFG_WORD_TWO ? CONFIG_WORD_2 : '0;
   assign rd_word = cfg_sel ? cfg_word : pm_mem[word_addr];

   // Only user IDs accept writes in configuration space.
   always_ff @(posedge sys_clk) begin
      if (wr_en && cfg_sel && user_hit) begin
         user_id_mem[cfg_addr[1:0]] <= wr_word;
      end else if (wr_en && !cfg_sel) begin
         pm_mem[word_addr] <= wr_word;
      end
   end
endmodule

/* File: verilog/flash_self_program_ctrl.sv */
// APB-reached controller for reading, erasing and writing the flash program memory.
`timescale 1ns/1ps
module flash_self_program_ctrl import flash_ctrl_pkg::*; #(
   parameter int unsigned OP_CYCLES = OP_WAIT_CYCLES,
   parameter logic [WORD_W-1:0] DEVICE_ID_WORD = 14'h1234,
   parameter logic [WORD_W-1:0] CONFIG_WORD_1 = 14'h3fff,
   parameter logic [WORD_W-1:0] CONFIG_WORD_2 = 14'h3fff
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic flash_busy
);
   // Software-visible state.
   logic [WORD_W-1:0] data_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic cfg_sel_reg;
   logic latch_only_reg;
   logic erase_reg;
   logic error_reg;
   logic enable_reg;
   logic wr_cmd_reg;
   logic rd_cmd_reg;
   logic [1:0] key_stage_reg;
   logic [1:0] key_stage_next;
   // Operation state.
   op_state_t state_reg;
   op_state_t state_next;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic op_cfg_reg;
   logic op_latch_reg;
   logic op_erase_reg;
   logic [ROW_W-1:0] op_row_reg;
   // Bus side.
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic busy_reg;

   // Bus decode.
   logic setup;
   logic wr_take;
   logic sel_data_low;
   logic sel_data_high;
   logic sel_addr_low;
   logic sel_addr_high;
   logic sel_ctrl;
   logic sel_key;
   logic mapped;
   logic ctrl_wr;
   logic key_wr;
   logic wr_try;
   logic rd_try;
   logic start_ok;
   logic [7:0] ctrl_view;
   logic [7:0] rd_mux;

   assign setup = psel & ~penable;
   assign sel_data_low = paddr == OFS_DATA_LOW;
   assign sel_data_high = paddr == OFS_DATA_HIGH;
   assign sel_addr_low = paddr == OFS_ADDR_LOW;
   assign sel_addr_high = paddr == OFS_ADDR_HIGH;
   assign sel_ctrl = paddr == OFS_CONTROL;
   assign sel_key = paddr == OFS_UNLOCK;
   assign mapped = sel_data_low | sel_data_high | sel_addr_low | sel_addr_high | sel_ctrl | sel_key;
   assign wr_take = psel & penable & pready_reg & pwrite & mapped;
   assign ctrl_wr = wr_take & sel_ctrl;
   assign key_wr = wr_take & sel_key;

   // Command decode; new control values take part in the same write.
   // error on set attempt
   assign wr_try = ctrl_wr & pwdata[CTRL_WRITE_BIT];
   assign rd_try = ctrl_wr & pwdata[CTRL_READ_BIT] & (state_reg == ST_IDLE) & ~start_ok;
   assign start_ok = wr_try & (key_stage_reg == 2'd2) & pwdata[CTRL_ENABLE_BIT] &
                     (state_reg == ST_IDLE) & ~wr_cmd_reg;

   // Read view of the registers; unused top bits follow their fixed levels.
   // top bit reads one
   assign ctrl_view = {1'b1, cfg_sel_reg, latch_only_reg, erase_reg, error_reg, enable_reg,
                       wr_cmd_reg, rd_cmd_reg};
   assign rd_mux = sel_data_low ? data_reg[7:0] :
                   sel_data_high ? {2'b00, data_reg[WORD_W-1:8]} :
                   sel_addr_low ? addr_reg[7:0] :
                   sel_addr_high ? {1'b1, addr_reg[ADDR_W-1:8]} :
                   sel_ctrl ? ctrl_view : 8'h00;

   // Unlock tracker: any mapped write other than the expected key breaks the sequence.
   always_comb begin
      key_stage_next = key_stage_reg;
      if (key_wr && pwdata[7:0] == KEY_FIRST) begin
         key_stage_next = 2'd1;
      end else if (key_wr && key_stage_reg == 2'd1 && pwdata[7:0] == KEY_SECOND) begin
         key_stage_next = 2'd2;
      end else if (wr_take) begin
         key_stage_next = 2'd0;
      end
   end

   // Memory-side wiring.
   logic [WORD_W-1:0] store_rd;
   logic [WORD_W-1:0] latch_rd;
   logic [WORD_W-1:0] store_wr;
   logic store_we;
   logic row_op;
   logic [ADDR_W-1:0] store_addr;
   logic load_en;
   logic abort;
   logic op_end;
   logic load_end;
   logic finish;

   assign row_op = state_reg == ST_PROG || state_reg == ST_ERASE;
   assign store_addr = row_op ? {op_row_reg, cnt_reg[LATCH_IDX_W-1:0]} : addr_reg;
   assign store_we = row_op;
   // Flash cells only move toward zero, so a program ANDs the latch into the old word.
   assign store_wr = (state_reg == ST_ERASE) ? BLANK_WORD : (store_rd & latch_rd);
   assign load_en = state_reg == ST_LOAD;
   // Dropping the enable bit mid-operation aborts it; the error flag takes the error bit of that same control write.
   assign abort = ~enable_reg & (row_op | state_reg == ST_LOAD | state_reg == ST_WAIT);
   assign op_end = state_reg == ST_WAIT && cnt_reg == 16'(OP_CYCLES - 1) && !abort;
   assign load_end = load_en && op_latch_reg && !abort;
   assign finish = op_end | load_end;

   flash_write_latches #(
      .COUNT(LATCH_COUNT),
      .W(WORD_W)
   ) u_latches (
      .sys_clk(sys_clk),
      .rst(rst),
      .load_en(load_en & ~abort),
      .load_idx(addr_reg[LATCH_IDX_W-1:0]),
      .load_word(data_reg),
      .blank_all(op_end),
      .rd_idx(cnt_reg[LATCH_IDX_W-1:0]),
      .rd_word(latch_rd)
   );

   flash_word_store #(
      .DEPTH(2 ** ADDR_W),
      .DEVICE_ID_WORD(DEVICE_ID_WORD),
      .CONFIG_WORD_1(CONFIG_WORD_1),
      .CONFIG_WORD_2(CONFIG_WORD_2)
   ) u_store (
      .sys_clk(sys_clk),
      .cfg_sel(row_op ? op_cfg_reg : cfg_sel_reg),
      .word_addr(store_addr),
      .rd_word(store_rd),
      .wr_en(store_we & ~abort),
      .wr_word(store_wr)
   );

   // Operation sequencer.
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         ST_IDLE: begin
            cnt_next = 16'h0000;
            if (start_ok && pwdata[CTRL_ERASE_BIT]) begin
               state_next = ST_ERASE;
            end else if (start_ok) begin
               state_next = ST_LOAD;
            end else if (rd_try) begin
               state_next = ST_READ;
            end
         end
         ST_READ: begin
            state_next = ST_IDLE;
         end
         ST_LOAD: begin
            state_next = (abort || op_latch_reg) ? ST_IDLE : ST_PROG;
         end
         ST_PROG, ST_ERASE: begin
            cnt_next = cnt_reg + 16'h0001;
            if (abort) begin
               state_next = ST_IDLE;
            end else if (cnt_reg == 16'(LATCH_COUNT - 1)) begin
               state_next = ST_WAIT;
               cnt_next = 16'h0000;
            end
         end
         ST_WAIT: begin
            cnt_next = cnt_reg + 16'h0001;
            if (abort || op_end) begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   // Sequencer and operation snapshot.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         cnt_reg <= 16'h0000;
         key_stage_reg <= 2'd0;
         op_cfg_reg <= 1'b0;
         op_latch_reg <= 1'b0;
         op_erase_reg <= 1'b0;
         op_row_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         key_stage_reg <= key_stage_next;
         if (start_ok) begin
            op_cfg_reg <= pwdata[CTRL_CFG_BIT];
            op_latch_reg <= pwdata[CTRL_LATCH_BIT];
            op_erase_reg <= pwdata[CTRL_ERASE_BIT];
            op_row_reg <= addr_reg[ADDR_W-1:LATCH_IDX_W];
         end
      end
   end

   // Data and address registers; a fetch overwrites the data pair.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         data_reg <= DATA_RST;
         addr_reg <= {ADDR_HIGH_RST, ADDR_LOW_RST};
      end else begin
         if (state_reg == ST_READ) begin
            data_reg <= store_rd;
         end else if (wr_take && sel_data_low) begin
            data_reg[7:0] <= pwdata[7:0];
         end else if (wr_take && sel_data_high) begin
            data_reg[WORD_W-1:8] <= pwdata[5:0];
         end
         if (wr_take && sel_addr_low) begin
            addr_reg[7:0] <= pwdata[7:0];
         end else if (wr_take && sel_addr_high) begin
            addr_reg[ADDR_W-1:8] <= pwdata[6:0];
         end
      end
   end

   // Control bits; hardware set wins over any clear in the same cycle.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg_sel_reg <= CTRL_BIT_RST;
         latch_only_reg <= CTRL_BIT_RST;
         erase_reg <= CTRL_BIT_RST;
         error_reg <= CTRL_BIT_RST;
         enable_reg <= CTRL_BIT_RST;
         wr_cmd_reg <= CTRL_BIT_RST;
         rd_cmd_reg <= CTRL_BIT_RST;
      end else begin
         if (ctrl_wr) begin
            cfg_sel_reg <= pwdata[CTRL_CFG_BIT];
            latch_only_reg <= pwdata[CTRL_LATCH_BIT];
            enable_reg <= pwdata[CTRL_ENABLE_BIT];
         end
         if (ctrl_wr) begin
            erase_reg <= pwdata[CTRL_ERASE_BIT];
         end else if (op_end && op_erase_reg) begin
            erase_reg <= 1'b0;
         end
         if (wr_try) begin
            error_reg <= 1'b1;
         end else if (finish) begin
            error_reg <= 1'b0;
         end else if (ctrl_wr) begin
            error_reg <= pwdata[CTRL_ERROR_BIT];
         end
         if (start_ok) begin
            wr_cmd_reg <= 1'b1;
         end else if (finish || abort) begin
            wr_cmd_reg <= 1'b0;
         end
         if (rd_try) begin
            rd_cmd_reg <= 1'b1;
         end else if (state_reg == ST_READ) begin
            rd_cmd_reg <= 1'b0;
         end
      end
   end

   // APB answer: one wait-free access phase, data captured at setup.
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~mapped;
         if (setup) begin
            prdata_reg <= {24'h000000, rd_mux};
         end
         busy_reg <= state_next != ST_IDLE;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign flash_busy = busy_reg;
endmodule

/* File: test/flash_self_program_ctrl_chk.sv */
// Concurrent checks on the ports of the flash self-program controller.
`timescale 1ns/1ps
module flash_self_program_ctrl_chk import flash_ctrl_pkg::*; #(
   parameter int unsigned OP_CYCLES = OP_WAIT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic flash_busy
);
   // A program spends one load cycle, the row walk and the timed wait; slack covers the read fetch too.
   localparam int BUSY_MAX = OP_CYCLES + 40;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Access kinds used by several properties.
   wire logic rd_acc = pready && !pwrite;
   wire logic ctl_wr = pready && pwrite && paddr == OFS_CONTROL;
   wire logic ctl_off = ctl_wr && !pwdata[CTRL_ENABLE_BIT] && !pwdata[CTRL_READ_BIT];
   a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("pready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   a_unmapped_err: assert property (pready && paddr > OFS_UNLOCK |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_no_err: assert property (pready && paddr <= OFS_UNLOCK && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("mapped access refused");
   a_ctrl_top_one: assert property (rd_acc && paddr == OFS_CONTROL |-> prdata[7] && prdata[31:8] == 24'h0)
      else $error("control top bit not one");
   a_addr_top_one: assert property (rd_acc && paddr == OFS_ADDR_HIGH |-> prdata[7])
      else $error("address high top bit not one");
   a_data_high_zero: assert property (rd_acc && paddr == OFS_DATA_HIGH |-> prdata[7:6] == 2'b00)
      else $error("data high upper bits not zero");
   a_busy_has_cause: assert property ($rose(flash_busy) |-> $past(ctl_wr))
      else $error("busy rose without a control write");
   a_busy_bounded: assert property ($rose(flash_busy) |-> ##[1:BUSY_MAX] !flash_busy)
      else $error("operation never finished");
   a_disabled_idle: assert property (ctl_off && !flash_busy |=> !flash_busy)
      else $error("operation started while disabled");
   c_busy: cover property ($rose(flash_busy));
   c_erase_cmd: cover property (ctl_wr && pwdata[CTRL_ERASE_BIT] && pwdata[CTRL_WRITE_BIT]);
   c_refused: cover property (pready && pslverr);
endmodule

bind flash_self_program_ctrl flash_self_program_ctrl_chk #(.OP_CYCLES(OP_CYCLES)) u_chk (
   .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_busy(flash_busy));

/* File: test/tb_flash_self_program_ctrl.sv */
// Self-checking bench for the flash self-program controller.
`timescale 1ns/1ps
module tb_flash_self_program_ctrl import flash_ctrl_pkg::*; ;
   localparam int unsigned OPC = 4;
   // Arbitrary identity and configuration contents for this bench.
   localparam logic [WORD_W-1:0] ID_W = 14'h2c5a;
   localparam logic [WORD_W-1:0] CW1 = 14'h1b3d;
   localparam logic [WORD_W-1:0] CW2 = 14'h0e71;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic flash_busy;
   logic [31:0] rdat;
   logic rerr;
   logic [7:0] a, d, lo;
   logic [WORD_W-1:0] v1, v2, v3;
   int failures = 0;
   int total_checks = 0;

   always #4 sys_clk = ~sys_clk;

   flash_self_program_ctrl #(.OP_CYCLES(OPC), .DEVICE_ID_WORD(ID_W), .CONFIG_WORD_1(CW1), .CONFIG_WORD_2(CW2)) u_dut (
      .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_busy(flash_busy));

   // Read-back value of a data or address register after a write.
   function automatic logic [7:0] reg_exp(logic [7:0] ofs, logic [7:0] val);
      return (ofs == OFS_DATA_HIGH) ? (val & 8'h3f) : (ofs == OFS_ADDR_HIGH) ? (val | 8'h80) : val;
   endfunction

   task summarize();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task chk8(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
      end
   endtask

   task chkw(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t word got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; pready and the answer are taken at the rising edge that ends the access phase.
   // Only the watchdog ends a wait that never sees pready, so a hung slave still reaches the verdict.
   task xfer(input logic [7:0] ad, input logic w, input logic [7:0] dt);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= {24'h0, dt};
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] ad, input logic [7:0] dt);
      xfer(ad, 1'b1, dt);
   endtask

   task rd(input logic [7:0] ad, input logic [31:0] exp);
      xfer(ad, 1'b0, 8'h00);
      chk8(rdat, exp);
   endtask

   // Busy rises one edge after the command, so two falling edges pass before polling.
   task wait_idle();
      repeat (2) @(negedge sys_clk);
      while (flash_busy !== 1'b0) begin
         @(negedge sys_clk);
      end
   endtask

   task setad(input logic [ADDR_W-1:0] wa);
      wr(OFS_ADDR_HIGH, {1'b0, wa[14:8]});
      wr(OFS_ADDR_LOW, wa[7:0]);
   endtask

   task at(input logic [ADDR_W-1:0] wa, input logic [WORD_W-1:0] wd);
      setad(wa);
      wr(OFS_DATA_HIGH, {2'b00, wd[13:8]});
      wr(OFS_DATA_LOW, wd[7:0]);
   endtask

   task cmd(input logic [7:0] c);
      wr(OFS_UNLOCK, KEY_FIRST);
      wr(OFS_UNLOCK, KEY_SECOND);
      wr(OFS_CONTROL, c);
      wait_idle();
   endtask

   task fetch(input logic [ADDR_W-1:0] wa, input logic cfg, input logic [WORD_W-1:0] exp);
      setad(wa);
      wr(OFS_CONTROL, {1'b0, cfg, 6'h01});
      wait_idle();
      xfer(OFS_DATA_LOW, 1'b0, 8'h00);
      lo = rdat[7:0];
      xfer(OFS_DATA_HIGH, 1'b0, 8'h00);
      chkw({rdat[5:0], lo}, exp);
   endtask

   initial begin
      #100000;
      failures++;
      summarize();
   end

   initial begin
      void'($urandom(96243));
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      rd(OFS_DATA_LOW, 32'h0);
      rd(OFS_DATA_HIGH, 32'h0);
      rd(OFS_ADDR_HIGH, 32'h80);
      rd(OFS_CONTROL, 32'h80);
      rd(OFS_UNLOCK, 32'h0);
      xfer(8'h18, 1'b0, 8'h00);
      chk8({31'h0, rerr}, 32'h1);
      chk8(rdat, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         d = (i < 4) ? 8'hff : 8'($urandom);
         a = 8'(4 * (i % 4));
         wr(a, d);
         rd(a, {24'h0, reg_exp(a, d)});
      end
      wr(OFS_CONTROL, 8'h60);
      rd(OFS_CONTROL, 32'he0);
      $display("test registers done");
      setad(15'h0043);
      cmd(8'h36);
      rd(OFS_CONTROL, 32'ha4);
      fetch(15'h0043, 1'b0, 14'h3fff);
      v1 = 14'($urandom);
      v2 = 14'($urandom);
      v3 = 14'($urandom);
      at(15'h0043, v1);
      cmd(8'h26);
      rd(OFS_CONTROL, 32'ha4);
      fetch(15'h0043, 1'b0, 14'h3fff);
      at(15'h0045, v2);
      wr(OFS_UNLOCK, KEY_FIRST);
      wr(OFS_UNLOCK, KEY_SECOND);
      wr(OFS_CONTROL, 8'h06);
      wr(OFS_CONTROL, 8'h0c);
      rd(OFS_CONTROL, 32'h8e);
      wait_idle();
      rd(OFS_CONTROL, 32'h84);
      fetch(15'h0043, 1'b0, v1);
      fetch(15'h0045, 1'b0, v2);
      fetch(15'h0044, 1'b0, 14'h3fff);
      at(15'h0063, v3);
      cmd(8'h26);
      setad(15'h0060);
      cmd(8'h16);
      at(15'h0066, v3);
      cmd(8'h06);
      fetch(15'h0063, 1'b0, 14'h3fff);
      fetch(15'h0066, 1'b0, v3);
      $display("test program done");
      at(15'h0043, 14'h0000);
      wr(OFS_UNLOCK, KEY_SECOND);
      wr(OFS_UNLOCK, KEY_FIRST);
      wr(OFS_CONTROL, 8'h06);
      rd(OFS_CONTROL, 32'h8c);
      cmd(8'h02);
      rd(OFS_CONTROL, 32'h88);
      fetch(15'h0043, 1'b0, v1);
      // enable drop aborts; the row walk stops before the loaded latch is reached.
      at(15'h0047, 14'h0000);
      wr(OFS_UNLOCK, KEY_FIRST);
      wr(OFS_UNLOCK, KEY_SECOND);
      wr(OFS_CONTROL, 8'h06);
      wr(OFS_CONTROL, 8'h08);
      wait_idle();
      rd(OFS_CONTROL, 32'h88);
      fetch(15'h0047, 1'b0, 14'h3fff);
      $display("test refusal done");
      setad(15'h0000);
      cmd(8'h56);
      at(15'h0002, v2);
      cmd(8'h46);
      fetch(15'h0002, 1'b1, v2);
      at(15'h0006, 14'h0000);
      cmd(8'h46);
      fetch(15'h0006, 1'b1, ID_W);
      fetch(15'h0007, 1'b1, CW1);
      fetch(15'h0008, 1'b1, CW2);
      fetch(15'h0043, 1'b1, 14'h0000);
      $display("test config done");
      summarize();
   end
endmodule
